// ==== src/gpbe_map.vh ====
// register map, field positions and reset values of the port block
// assumes a 32-bit axi4-lite slave; byte address is four times the index
//
// Behaviour
// [RULE1] port c direction bit 1 floats the pin, 0 drives it from latch
// [RULE2] an enabled peripheral may force a port c pin to input or output
// [RULE3] software avoids read-modify-write of port c direction during override
// [RULE4] port c bits 0,1,2,6,7 are the ones shared with peripherals
// [RULE5] port d has eight pins, each independently input or output
// [RULE6] port e mode bit 4 turns port d into a parallel slave port
// [RULE7] in slave mode pin n of port d carries data bit n
// [RULE8] port e has three pins set by direction bits 2 to 0
// [RULE9] in slave mode port e pins are read, write and select strobes
// [RULE10] software sets port e inputs and digital before slave mode
// [RULE11] analog-selected port e pins read back as zero
// [RULE12] port e direction bits still drive analog pins; keep them inputs
// [RULE13] power-on reset makes all port e pins analog inputs
// [RULE14] port b direction resets to all ones, mirrored at index 186h
// [RULE15] port e status register layout, bit 3 reads zero, resets 0000-111
// [RULE16] data reads return pins, data writes load latch driving outputs
// [RULE17] clearing option bit 7 enables pull-ups on port b input pins
// [RULE18] external processor reads or writes port d latch without a clock
`ifndef GPBE_MAP_VH
`define GPBE_MAP_VH

// register indexes
`define GPBE_IDX_PB      9'h006
`define GPBE_IDX_PB_ALT  9'h106
`define GPBE_IDX_PC      9'h007
`define GPBE_IDX_PD      9'h008
`define GPBE_IDX_PE      9'h009
`define GPBE_IDX_OPT     9'h081
`define GPBE_IDX_OPT_ALT 9'h181
`define GPBE_IDX_TB      9'h086
`define GPBE_IDX_TB_ALT  9'h186
`define GPBE_IDX_TC      9'h087
`define GPBE_IDX_TD      9'h088
`define GPBE_IDX_TE      9'h089
`define GPBE_IDX_ANA     9'h09f

// decoded register selects
`define GPBE_SEL_NONE 4'h0
`define GPBE_SEL_PB   4'h1
`define GPBE_SEL_PC   4'h2
`define GPBE_SEL_PD   4'h3
`define GPBE_SEL_PE   4'h4
`define GPBE_SEL_OPT  4'h5
`define GPBE_SEL_TB   4'h6
`define GPBE_SEL_TC   4'h7
`define GPBE_SEL_TD   4'h8
`define GPBE_SEL_TE   4'h9
`define GPBE_SEL_ANA  4'ha

// fields
`define GPBE_OPT_PU_BIT 7
`define GPBE_TE_IN_FULL  7
`define GPBE_TE_OUT_FULL 6
`define GPBE_TE_IN_OVF   5
`define GPBE_TE_MODE    4
`define GPBE_PE_RD      0
`define GPBE_PE_WR      1
`define GPBE_PE_CS      2
`define GPBE_C_SHARED   8'hc7

// reset values
`define GPBE_RST_TRIS8  8'hff
`define GPBE_RST_TRIS3  3'h7
`define GPBE_RST_OPT    8'hff
`define GPBE_RST_ANA    3'h7
`define GPBE_RST_LATCH  8'h00

// bus answers
`define GPBE_RESP_OKAY   2'h0
`define GPBE_RESP_SLVERR 2'h2

`endif

// ==== src/gpbe_top.v ====
// ports b to e with direction, latches, port c override and slave port
// assumes axi4-lite master on mclk; pins and strobes are asynchronous
`timescale 1ns/1ps
`include "gpbe_map.vh"

module gpbe_top #(
    parameter AW = 12
) (
    input  wire          mclk,
    input  wire          rst,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire [7:0]    pin_b_in,
    output reg  [7:0]    pin_b_out,
    output reg  [7:0]    pin_b_oe,
    output reg  [7:0]    pin_b_pullup,
    input  wire [7:0]    pin_c_in,
    output reg  [7:0]    pin_c_out,
    output reg  [7:0]    pin_c_oe,
    input  wire [7:0]    periph_c_en,
    input  wire [7:0]    periph_c_dir,
    input  wire [7:0]    periph_c_out,
    input  wire [7:0]    pin_d_in,
    output reg  [7:0]    pin_d_out,
    output reg  [7:0]    pin_d_oe,
    input  wire [2:0]    pin_e_in,
    output reg  [2:0]    pin_e_out,
    output reg  [2:0]    pin_e_oe
);

    // index to register select; shared by the read and write paths
    function [3:0] gpbe_decode;
        input [AW-1:0] addr;
        begin
            case (addr[10:2])
                `GPBE_IDX_PB, `GPBE_IDX_PB_ALT:   gpbe_decode = `GPBE_SEL_PB;
                `GPBE_IDX_PC:                     gpbe_decode = `GPBE_SEL_PC;
                `GPBE_IDX_PD:                     gpbe_decode = `GPBE_SEL_PD;
                `GPBE_IDX_PE:                     gpbe_decode = `GPBE_SEL_PE;
                `GPBE_IDX_OPT, `GPBE_IDX_OPT_ALT: gpbe_decode = `GPBE_SEL_OPT;
                `GPBE_IDX_TB, `GPBE_IDX_TB_ALT:   gpbe_decode = `GPBE_SEL_TB; // RULE14
                `GPBE_IDX_TC:                     gpbe_decode = `GPBE_SEL_TC;
                `GPBE_IDX_TD:                     gpbe_decode = `GPBE_SEL_TD;
                `GPBE_IDX_TE:                     gpbe_decode = `GPBE_SEL_TE;
                `GPBE_IDX_ANA:                    gpbe_decode = `GPBE_SEL_ANA;
                default:                          gpbe_decode = `GPBE_SEL_NONE;
            endcase
        end
    endfunction

    // software state
    reg  [7:0]    latch_b;
    reg  [7:0]    latch_c;
    reg  [7:0]    latch_d;
    reg  [2:0]    latch_e;
    reg  [7:0]    pullup_edge_timer_options;
    reg  [7:0]    dir_b;
    reg  [7:0]    dir_c;
    reg  [7:0]    dir_d;
    reg  [2:0]    dir_e;
    reg  [2:0]    analog_pin_config;
    reg           slave_port_mode_select;
    reg           input_buffer_full;
    reg           output_buffer_full;
    reg           input_overflow;
    reg  [7:0]    slave_in_buf;

    // pin synchronisers, first stage read only by the second
    reg  [7:0]    b_m;
    reg  [7:0]    b_s;
    reg  [7:0]    c_m;
    reg  [7:0]    c_s;
    reg  [7:0]    d_m;
    reg  [7:0]    d_s;
    reg  [2:0]    e_m;
    reg  [2:0]    e_s;
    reg  [2:0]    e_q;

    // bus holding state
    reg           aw_got;
    reg           w_got;
    reg  [AW-1:0] aw_addr;
    reg  [31:0]   w_data;
    reg           w_lane0;

    wire          aw_take = s_axi_awready & s_axi_awvalid;
    wire          w_take  = s_axi_wready & s_axi_wvalid;
    wire          ar_take = s_axi_arready & s_axi_arvalid;
    wire          do_wr   = aw_got & w_got & ~s_axi_bvalid;
    wire [3:0]    wr_sel  = gpbe_decode(aw_addr);
    wire [3:0]    rd_sel  = gpbe_decode(s_axi_araddr);
    wire          wr_en   = do_wr & w_lane0;
    wire [7:0]    wb      = w_data[7:0];

    // strobes after synchronising; end strobes take select from previous sample, read drive from current
    wire          ext_wr_end = slave_port_mode_select & ~e_q[`GPBE_PE_WR]
                             & e_s[`GPBE_PE_WR] & ~e_q[`GPBE_PE_CS];       // RULE18
    wire          ext_rd_end = slave_port_mode_select & ~e_q[`GPBE_PE_RD]
                             & e_s[`GPBE_PE_RD] & ~e_q[`GPBE_PE_CS];       // RULE18
    wire          ext_rd_act = slave_port_mode_select & ~e_s[`GPBE_PE_RD]
                             & ~e_s[`GPBE_PE_CS];                          // RULE9
    wire          cpu_rd_d   = ar_take & (rd_sel == `GPBE_SEL_PD);

    // port c override limited to shared pins
    wire [7:0]    c_ovr   = periph_c_en & `GPBE_C_SHARED;                  // RULE4
    wire [7:0]    c_dir   = (c_ovr & periph_c_dir) | (~c_ovr & dir_c);     // RULE2
    wire [7:0]    c_drive = (c_ovr & periph_c_out) | (~c_ovr & latch_c);

    reg  [7:0]    next_rbyte;
    reg           next_rerr;
    reg  [7:0]    next_d_oe;
    reg  [7:0]    next_d_out;
    reg  [2:0]    next_e_oe;

    // two-flop synchronisers on every pin input
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            b_m <= 8'h00;
            b_s <= 8'h00;
            c_m <= 8'h00;
            c_s <= 8'h00;
            d_m <= 8'h00;
            d_s <= 8'h00;
            e_m <= 3'h7;
            e_s <= 3'h7;
            e_q <= 3'h7;
        end else begin
            b_m <= pin_b_in;
            b_s <= b_m;
            c_m <= pin_c_in;
            c_s <= c_m;
            d_m <= pin_d_in;
            d_s <= d_m;
            e_m <= pin_e_in;
            e_s <= e_m;
            e_q <= e_s;
        end
    end

    // read mux; status bits come back live, direction c as overridden
    always @* begin
        next_rerr  = 1'b0;
        next_rbyte = 8'h00;
        case (rd_sel)
            `GPBE_SEL_PB:  next_rbyte = b_s;                               // RULE16
            `GPBE_SEL_PC:  next_rbyte = c_s;
            `GPBE_SEL_PD:  next_rbyte = slave_port_mode_select ? slave_in_buf : d_s;
            `GPBE_SEL_PE:  next_rbyte = {5'h00, e_s & ~analog_pin_config}; // RULE11
            `GPBE_SEL_OPT: next_rbyte = pullup_edge_timer_options;
            `GPBE_SEL_TB:  next_rbyte = dir_b;
            `GPBE_SEL_TC:  next_rbyte = c_dir;                             // RULE3
            `GPBE_SEL_TD:  next_rbyte = dir_d;
            `GPBE_SEL_TE:  next_rbyte = {input_buffer_full, output_buffer_full,
                                         input_overflow, slave_port_mode_select,
                                         1'b0, dir_e};                     // RULE15
            `GPBE_SEL_ANA: next_rbyte = {5'h00, analog_pin_config};
            default:       next_rerr  = 1'b1;
        endcase
    end

    // write channel: address and data taken in either order
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= {AW{1'b0}};
            w_data        <= 32'h0;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GPBE_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_got <= 1'b0;
            end
            if (w_take) begin
                w_got   <= 1'b1;
                w_data  <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end else if (do_wr) begin
                w_got <= 1'b0;
            end
            // ready again only after the response is gone
            s_axi_awready <= ~aw_got & ~aw_take & ~s_axi_bvalid & ~do_wr;
            s_axi_wready  <= ~w_got & ~w_take & ~s_axi_bvalid & ~do_wr;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == `GPBE_SEL_NONE) ? `GPBE_RESP_SLVERR
                                                           : `GPBE_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `GPBE_RESP_OKAY;
        end else begin
            s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~s_axi_rready);
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, next_rbyte};
                s_axi_rresp  <= next_rerr ? `GPBE_RESP_SLVERR : `GPBE_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // register writes; one reset serves power-on and all other resets
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch_b           <= `GPBE_RST_LATCH;
            latch_c           <= `GPBE_RST_LATCH;
            latch_d           <= `GPBE_RST_LATCH;
            latch_e           <= 3'h0;
            pullup_edge_timer_options <= `GPBE_RST_OPT;                    // RULE17
            dir_b             <= `GPBE_RST_TRIS8;                          // RULE14
            dir_c             <= `GPBE_RST_TRIS8;
            dir_d             <= `GPBE_RST_TRIS8;
            dir_e             <= `GPBE_RST_TRIS3;                          // RULE15
            analog_pin_config <= `GPBE_RST_ANA;                            // RULE13
            slave_port_mode_select <= 1'b0;
        end else if (wr_en) begin
            case (wr_sel)
                `GPBE_SEL_PB:  latch_b <= wb;                              // RULE16
                `GPBE_SEL_PC:  latch_c <= wb;
                `GPBE_SEL_PD:  latch_d <= wb;
                `GPBE_SEL_PE:  latch_e <= wb[2:0];
                `GPBE_SEL_OPT: pullup_edge_timer_options <= wb;
                `GPBE_SEL_TB:  dir_b <= wb;
                `GPBE_SEL_TC:  dir_c <= wb;
                `GPBE_SEL_TD:  dir_d <= wb;                                // RULE5
                `GPBE_SEL_TE: begin
                    dir_e                  <= wb[2:0];                     // RULE8
                    slave_port_mode_select <= wb[`GPBE_TE_MODE];           // RULE6
                end
                `GPBE_SEL_ANA: analog_pin_config <= wb[2:0];
                default:       latch_e <= latch_e;
            endcase
        end
    end

    // slave port buffer and flags; a setting event beats a clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            slave_in_buf       <= 8'h00;
            input_buffer_full  <= 1'b0;
            output_buffer_full <= 1'b0;
            input_overflow     <= 1'b0;
        end else begin
            if (ext_wr_end) begin
                slave_in_buf      <= d_s;                                  // RULE7
                input_buffer_full <= 1'b1;
            end else if (cpu_rd_d & slave_port_mode_select) begin
                input_buffer_full <= 1'b0;
            end
            if (ext_wr_end & input_buffer_full) begin
                input_overflow <= 1'b1;
            end else if (wr_en & (wr_sel == `GPBE_SEL_TE) & ~wb[`GPBE_TE_IN_OVF]) begin
                input_overflow <= 1'b0;
            end
            if (wr_en & (wr_sel == `GPBE_SEL_PD) & slave_port_mode_select) begin
                output_buffer_full <= 1'b1;
            end else if (ext_rd_end) begin
                output_buffer_full <= 1'b0;
            end
        end
    end

    // port d and e drivers depend on slave mode
    always @* begin
        if (slave_port_mode_select) begin
            next_d_oe  = {8{ext_rd_act}};                                  // RULE6
            next_d_out = latch_d;                                          // RULE7
            next_e_oe  = 3'h0;                                             // RULE9
        end else begin
            next_d_oe  = ~dir_d;                                           // RULE5
            next_d_out = latch_d;
            next_e_oe  = ~dir_e;                                           // RULE12
        end
    end

    // registered pin drivers; direction bit 1 means floating input
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_b_out    <= 8'h00;
            pin_b_oe     <= 8'h00;
            pin_b_pullup <= 8'h00;
            pin_c_out    <= 8'h00;
            pin_c_oe     <= 8'h00;
            pin_d_out    <= 8'h00;
            pin_d_oe     <= 8'h00;
            pin_e_out    <= 3'h0;
            pin_e_oe     <= 3'h0;
        end else begin
            pin_b_out    <= latch_b;
            pin_b_oe     <= ~dir_b;
            pin_b_pullup <= {8{~pullup_edge_timer_options[`GPBE_OPT_PU_BIT]}} & dir_b; // RULE17
            pin_c_out    <= c_drive;                                       // RULE1
            pin_c_oe     <= ~c_dir;                                        // RULE1
            pin_d_out    <= next_d_out;
            pin_d_oe     <= next_d_oe;
            pin_e_out    <= latch_e;
            pin_e_oe     <= next_e_oe;                                     // RULE8
        end
    end

endmodule

// ==== tb/gpbe_top_assertions.sv ====
// checker on the port block's bus handshakes and pin outputs
// assumes a bind into gpbe_top; one clock, asynchronous reset
`timescale 1ns/1ps
module gpbe_checker (
    input wire        mclk,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire [7:0]  pin_b_oe,
    input wire [7:0]  pin_b_pullup,
    input wire [7:0]  periph_c_en,
    input wire [7:0]  periph_c_dir,
    input wire [7:0]  pin_c_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // pull-ups never fight a driven pin
    property p_pu_in; (pin_b_pullup & pin_b_oe) == 8'h00; endproperty
    a_pu_in: assert property (p_pu_in) else $error("pull-up on driven pin");
    // two cycles of override, so a registered pin stage has caught up
    property p_c_out; (periph_c_en[2] && !periph_c_dir[2]) [*2] |-> pin_c_oe[2]; endproperty
    a_c_out: assert property (p_c_out) else $error("override to output lost");
    property p_c_in; (periph_c_en[6] && periph_c_dir[6]) [*2] |-> !pin_c_oe[6]; endproperty
    a_c_in: assert property (p_c_in) else $error("override to input lost");
    // answers stand until taken, arrive in time and carry only the low byte
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed");
    property p_w_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_w_ans: assert property (p_w_ans) else $error("write answer late");
    property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_byte;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0);
    endproperty
    a_r_byte: assert property (p_r_byte) else $error("read data outside low byte");
endmodule

bind gpbe_top gpbe_checker i_gpbe_checker (.mclk(mclk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .pin_b_oe(pin_b_oe), .pin_b_pullup(pin_b_pullup), .periph_c_en(periph_c_en),
    .periph_c_dir(periph_c_dir), .pin_c_oe(pin_c_oe));

// ==== tb/gpbe_pins.sv ====
// outside world of the port block: pin levels and a processor on the slave port
// assumes mclk from the bench; the bench sets ext and ext_b_z directly, the tasks drive ext_e and d_rel
`timescale 1ns/1ps
module gpbe_pins (
    input  wire       mclk,
    input  wire [7:0] pin_b_out,
    input  wire [7:0] pin_b_oe,
    input  wire [7:0] pin_b_pullup,
    output wire [7:0] pin_b_in,
    input  wire [7:0] pin_c_out,
    input  wire [7:0] pin_c_oe,
    output wire [7:0] pin_c_in,
    input  wire [7:0] pin_d_out,
    input  wire [7:0] pin_d_oe,
    output wire [7:0] pin_d_in,
    input  wire [2:0] pin_e_out,
    input  wire [2:0] pin_e_oe,
    output wire [2:0] pin_e_in
);
    reg [23:0] ext;
    reg [7:0]  ext_b_z;
    reg [2:0]  ext_e;
    reg        d_rel;
    initial begin
        ext = 24'h0;
        ext_b_z = 8'h00;
        ext_e = 3'h7;
        d_rel = 1'b0;
    end
    // a floating line goes to its pull-up, else away from its last level
    assign pin_b_in = (pin_b_oe & pin_b_out) | (~pin_b_oe & ((ext_b_z & (pin_b_pullup
        | ~ext[7:0])) | (~ext_b_z & ext[7:0])));
    assign pin_c_in = (pin_c_oe & pin_c_out) | (~pin_c_oe & ext[15:8]);
    assign pin_d_in = (pin_d_oe & pin_d_out) | (~pin_d_oe & (d_rel ? ~ext[23:16] : ext[23:16]));
    assign pin_e_in = (pin_e_oe & pin_e_out) | (~pin_e_oe & ext_e);
    // outside write: strobes low four cycles, data held four past the rise
    task slave_write(input [7:0] v); begin
        @(posedge mclk);
        ext[23:16] <= v;
        d_rel <= 1'b0;
        ext_e <= 3'b001;
        repeat (4) @(posedge mclk);
        ext_e <= 3'b111;
        repeat (4) @(posedge mclk);
        d_rel <= 1'b1;
        repeat (2) @(posedge mclk);
    end endtask
    // outside read: sampled late in the strobe, as the drive starts synced
    task slave_read(output [7:0] v); begin
        @(posedge mclk);
        ext_e <= 3'b010;
        repeat (6) @(posedge mclk);
        v = pin_d_in;
        ext_e <= 3'b111;
        repeat (6) @(posedge mclk);
    end endtask
endmodule

// ==== tb/gpio_ports_b_to_e_tb.sv ====
// bench for the port block: axi4-lite master, expected values, pin partner
// assumes gpbe_top with a 12-bit address and gpbe_pins on its pins
`timescale 1ns/1ps
module gpio_ports_b_to_e_tb;
    reg         mclk, rst, awv, wv, brd, arv, rrd;
    reg  [11:0] awa, ara, p;
    reg  [31:0] wd;
    reg  [7:0]  pen, pdr, pout, d, l, x, y;
    reg  [3:0]  ws;
    reg  [23:0] ex;
    wire        awr, wrr, bv, arr, rv;
    wire [1:0]  bre, rre;
    wire [31:0] rdt;
    wire [7:0]  bi, bo, boe, bpu, ci, co, coe, di, dout, doe;
    wire [2:0]  ei, eo, eoe;
    wire [23:0] oes = {doe, coe, boe};
    wire [23:0] outs = {dout, co, bo};
    integer     n_errors, n_compared, i, k, seed;
    // reset table: address and expected value, read from the low slice up
    reg [107:0] ta = {12'h218, 12'h618, 12'h21c, 12'h220, 12'h224, 12'h204, 12'h604, 12'h27c,
        12'h024};
    reg [71:0]  tv = {8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'h07, 8'h00};
    gpbe_top i_gpbe_top (.mclk(mclk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rrd), .pin_b_in(bi), .pin_b_out(bo),
        .pin_b_oe(boe), .pin_b_pullup(bpu), .pin_c_in(ci), .pin_c_out(co), .pin_c_oe(coe),
        .periph_c_en(pen), .periph_c_dir(pdr), .periph_c_out(pout), .pin_d_in(di),
        .pin_d_out(dout), .pin_d_oe(doe), .pin_e_in(ei), .pin_e_out(eo), .pin_e_oe(eoe));
    gpbe_pins i_gpbe_pins (.mclk(mclk), .pin_b_out(bo), .pin_b_oe(boe), .pin_b_pullup(bpu),
        .pin_b_in(bi), .pin_c_out(co), .pin_c_oe(coe), .pin_c_in(ci), .pin_d_out(dout),
        .pin_d_oe(doe), .pin_d_in(di), .pin_e_out(eo), .pin_e_oe(eoe), .pin_e_in(ei));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task chk(input [31:0] s, input [31:0] e); begin
        n_compared = n_compared + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    end endtask
    task print_verdict; begin
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    // one write; address and data offered together, each released once taken
    task axw(input [11:0] a, input [7:0] v, input [1:0] er); begin
        @(posedge mclk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
            if (bv) i = 99;
        end
        brd <= 1'b0;
        if (i == 64) n_errors = n_errors + 1;
        if (i == 64) print_verdict;
        chk(bre, er);
    end endtask
    task axr(input [11:0] a, input [7:0] e, input [1:0] er); begin
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
            if (rv) i = 99;
        end
        rrd <= 1'b0;
        if (i == 64) n_errors = n_errors + 1;
        if (i == 64) print_verdict;
        chk(rdt, {24'h0, e});
        chk(rre, er);
    end endtask
    initial begin
        n_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        {awa, ara, wd, awv, wv, brd, arv, rrd, pen, pdr, pout} = 0;
        ws = 4'h1;
        seed = $urandom(32'h29e1);
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (k = 0; k < 9; k = k + 1) axr(ta[k*12 +: 12], tv[k*8 +: 8], 2'h0);
        axr(12'h3f0, 8'h00, 2'h2);
        chk({boe, bpu, eoe}, 19'h0);
        $display("reset test done");
        // random direction and latch; undriven pins read the outside level
        for (k = 0; k < 6; k = k + 1) begin
            p = 12'(k % 3);
            d = 8'($urandom);
            l = 8'($urandom);
            ex = 24'($urandom);
            i_gpbe_pins.ext <= ex;
            axw(12'h218 + (p << 2), d, 2'h0);
            axw(12'h018 + (p << 2), l, 2'h0);
            repeat (3) @(posedge mclk);
            chk(oes[p*8 +: 8], {~d});
            chk(outs[p*8 +: 8] & ~d, l & ~d);
            axr(12'h018 + (p << 2), (l & ~d) | (ex[p*8 +: 8] & d), 2'h0);
        end
        $display("direction test done");
        i_gpbe_pins.ext_b_z <= 8'hff;
        i_gpbe_pins.ext[7:0] <= 8'hff;
        axw(12'h604, 8'h7f, 2'h0);
        axw(12'h618, d, 2'h0);
        axw(12'h418, l, 2'h0);
        repeat (3) @(posedge mclk);
        chk(bpu, d);
        axr(12'h218, d, 2'h0);
        axr(12'h018, (l & ~d) | d, 2'h0);
        axw(12'h204, 8'hff, 2'h0);
        repeat (3) @(posedge mclk);
        chk(bpu, 8'h00);
        axr(12'h018, l & ~d, 2'h0);
        $display("pull-up test done");
        for (k = 0; k < 4; k = k + 1) begin
            d = 8'($urandom);
            l = 8'($urandom);
            // pins 2 and 6 always overridden so both override checks fire
            pen <= 8'($urandom) | 8'h44;
            pdr <= (k < 2) ? ((8'($urandom) | 8'h40) & 8'hfb) : 8'($urandom);
            pout <= 8'($urandom);
            axw(12'h21c, d, 2'h0);
            axw(12'h01c, l, 2'h0);
            repeat (2) @(posedge mclk);
            x = pen & 8'hc7;
            y = (x & pdr) | (~x & d);
            chk(coe, {~y});
            chk(co & ~y, ((x & pout) | (~x & l)) & ~y);
            axr(12'h21c, y, 2'h0);
        end
        pen <= 8'h00;
        $display("override test done");
        l = 8'($urandom);
        axw(12'h27c, 8'h00, 2'h0);
        axw(12'h224, 8'h00, 2'h0);
        axw(12'h024, l, 2'h0);
        repeat (3) @(posedge mclk);
        chk({eoe, eo}, {3'h7, l[2:0]});
        axr(12'h024, {5'h0, l[2:0]}, 2'h0);
        // a write with lane 0 off must leave the latch alone
        ws <= 4'h0;
        axw(12'h024, ~l, 2'h0);
        ws <= 4'h1;
        axr(12'h024, {5'h0, l[2:0]}, 2'h0);
        axw(12'h27c, 8'h07, 2'h0);
        repeat (2) @(posedge mclk);
        chk(eoe, 3'h7);
        axr(12'h024, 8'h00, 2'h0);
        axw(12'h224, 8'h07, 2'h0);
        repeat (2) @(posedge mclk);
        chk(eoe, 3'h0);
        $display("port e test done");
        axw(12'h27c, 8'h00, 2'h0);
        axw(12'h224, 8'hff, 2'h0);
        axr(12'h224, 8'h17, 2'h0);
        x = 8'($urandom);
        i_gpbe_pins.slave_write(x);
        axr(12'h224, 8'h97, 2'h0);
        axr(12'h020, x, 2'h0);
        i_gpbe_pins.slave_write(x);
        i_gpbe_pins.slave_write(~x);
        axr(12'h224, 8'hb7, 2'h0);
        axr(12'h020, ~x, 2'h0);
        axw(12'h224, 8'h17, 2'h0);
        y = 8'($urandom);
        axw(12'h020, y, 2'h0);
        axr(12'h224, 8'h57, 2'h0);
        chk({doe, eoe}, 11'h0);
        i_gpbe_pins.slave_read(l);
        chk(l, y);
        axr(12'h224, 8'h17, 2'h0);
        axw(12'h3f0, 8'h00, 2'h2);
        $display("slave port test done");
        print_verdict;
    end
endmodule
